// *** cbu_defines.svh ***
// Constants for the conditional branch unit
// Functional notes
// - Upper opcode byte 0xE6 branches only when the negative flag is one.
// - Upper opcode byte 0xE3 branches only when the carry flag is zero.
// - Upper opcode byte 0xE7 branches only when the negative flag is zero.
// - Upper opcode byte 0xE5 branches only when the overflow flag is zero.
// - The lower opcode byte is a signed offset from -128 to 127, doubled before use.
// - A taken branch loads branch address plus 2 plus twice the offset.
// - A branch takes one cycle when not taken and two cycles when taken.
// - Decode in Q1, read offset in Q2, process in Q3, write PC in Q4 if taken; the second cycle is idle.
// - These branches never change any status flag.
`ifndef CBU_DEFINES_SVH
`define CBU_DEFINES_SVH
`define CBU_OP_NEG     8'hE6
`define CBU_OP_NO_C    8'hE3
`define CBU_OP_NON_NEG 8'hE7
`define CBU_OP_NO_OV   8'hE5
`define CBU_PC_STEP    2
`define CBU_PC_RESET   21'h000000
`endif

// *** cbu_pkg.sv ***
// Types for the conditional branch unit
package cbu_pkg;
	typedef enum logic [1:0] {
		cbu_q1,
		cbu_q2,
		cbu_q3,
		cbu_q4
	} cbu_phase_e;
	typedef struct packed {
		logic neg;
		logic ovf;
		logic carry;
	} cbu_flags_s;
	typedef struct packed {
		logic        load;
		logic [20:0] target;
	} cbu_pc_load_s;
endpackage : cbu_pkg

// *** cbu_branch.sv ***
// Conditional relative branch decode and execute
`timescale 1ns/1ns
`default_nettype none
`include "cbu_defines.svh"
module cbu_branch
	import cbu_pkg::*;
#(
	parameter int PC_W = 21
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        q_tick,
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr,
	input  wire logic [PC_W-1:0] pc_inc,
	input  wire cbu_flags_s  flags,
	output cbu_pc_load_s     pc_load,
	output logic             is_branch,
	output logic             taken,
	output logic             flush,
	output logic [1:0]       phase
);
	initial begin
		if (PC_W != 21) $error("cbu_branch supports PC_W of 21 only");
	end

	cbu_phase_e q;
	logic        active;
	logic        cond_ok;
	logic        flush_cyc;
	logic [7:0]  off_lat;
	logic [PC_W-1:0] tgt;

	// Decode table used at Q1 only; is_branch and taken come from the registers latched there, flush from the Q4 register
	function automatic logic [1:0] cbu_dec(input logic [7:0] op);
		case (op)
			`CBU_OP_NEG:     cbu_dec = 2'h0;
			`CBU_OP_NO_C:    cbu_dec = 2'h1;
			`CBU_OP_NON_NEG: cbu_dec = 2'h2;
			`CBU_OP_NO_OV:   cbu_dec = 2'h3;
			default:         cbu_dec = 2'h0;
		endcase
	endfunction : cbu_dec

	wire op_hit = (instr[15:8] == `CBU_OP_NEG) || (instr[15:8] == `CBU_OP_NO_C) ||
		(instr[15:8] == `CBU_OP_NON_NEG) || (instr[15:8] == `CBU_OP_NO_OV);
	wire [1:0] kind = cbu_dec(instr[15:8]);
	wire cond_now = (kind == 2'h0) ? flags.neg :
		(kind == 2'h1) ? !flags.carry :
		(kind == 2'h2) ? !flags.neg :
		!flags.ovf;
	// Sign-extend then double the offset
	wire [PC_W-1:0] off2 = {{(PC_W-9){off_lat[7]}}, off_lat, 1'b0};
	wire start = q_tick && (q == cbu_q1) && instr_valid && op_hit && !flush_cyc;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) q <= cbu_q1;
		else if (q_tick) begin
			case (q)
				cbu_q1:  q <= cbu_q2;
				cbu_q2:  q <= cbu_q3;
				cbu_q3:  q <= cbu_q4;
				cbu_q4:  q <= cbu_q1;
				default: q <= cbu_q1;
			endcase
		end
	end

	// Phase strobes; one enable per register keeps each process short
	wire dec_tick  = start;
	wire rd_tick   = q_tick && active && (q == cbu_q2);
	wire proc_tick = q_tick && active && (q == cbu_q3);
	wire end_tick  = q_tick && (q == cbu_q4);
	wire wr_tick   = end_tick && active && cond_ok;

	// Flags sampled at decode; status is only read, never written
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) active <= 1'b0;
		else if (dec_tick) active <= 1'b1;
		else if (end_tick) active <= 1'b0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) cond_ok <= 1'b0;
		else if (dec_tick) cond_ok <= cond_now;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) off_lat <= 8'h00;
		else if (rd_tick) off_lat <= instr[7:0];
	end

	// Counter is already past the branch word, so no extra step here
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) tgt <= '0;
		else if (proc_tick) tgt <= PC_W'(pc_inc + off2);
	end

	// Taken branch spends the next whole cycle as no-operation
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) flush_cyc <= 1'b0;
		else if (q_tick && q == cbu_q4) flush_cyc <= active && cond_ok;
	end

	// PC load only in Q4 of a taken branch; untaken leaves pc_inc
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) pc_load <= '{load: 1'b0, target: `CBU_PC_RESET};
		else begin
			pc_load.load <= wr_tick;
			if (wr_tick) pc_load.target <= tgt;
		end
	end

	assign is_branch = active;
	assign taken     = active && cond_ok;
	assign flush     = flush_cyc;
	assign phase     = q;

	// Program counter write
	load_only_q4_a : assert property (@(posedge clk) disable iff (!nrst)
		pc_load.load |-> $past(q) == cbu_q4 && $past(q_tick) && $past(active) && $past(cond_ok))
		else $error("PC load outside Q4 of taken branch");

	no_load_fail_a : assert property (@(posedge clk) disable iff (!nrst)
		pc_load.load |-> !$past(flush_cyc))
		else $error("PC load during flush cycle");

	load_pulse_a : assert property (@(posedge clk) disable iff (!nrst)
		pc_load.load |=> !pc_load.load)
		else $error("PC load longer than one clock");

	target_hold_a : assert property (@(posedge clk) disable iff (!nrst)
		!wr_tick |=> $stable(pc_load.target))
		else $error("PC target moved without a load");

	untaken_quiet_a : assert property (@(posedge clk) disable iff (!nrst)
		q_tick && active && !cond_ok && q == cbu_q4 |=> !pc_load.load && !flush_cyc)
		else $error("Untaken branch loaded PC");

	// Offset and target
	offset_latch_a : assert property (@(posedge clk) disable iff (!nrst)
		rd_tick |=> off_lat == $past(instr[7:0]))
		else $error("Offset not taken in Q2");

	offset_sign_a : assert property (@(posedge clk) disable iff (!nrst)
		$signed(off2) == $signed(off_lat) * 2)
		else $error("Offset not sign-extended and doubled");

	target_math_a : assert property (@(posedge clk) disable iff (!nrst)
		proc_tick |=> tgt == $past(pc_inc) + $past(off2))
		else $error("Branch target wrong");

	// Decode and condition
	neg_cond_a : assert property (@(posedge clk) disable iff (!nrst)
		start && instr[15:8] == `CBU_OP_NEG |=> cond_ok == $past(flags.neg))
		else $error("Negative branch condition wrong");

	noc_cond_a : assert property (@(posedge clk) disable iff (!nrst)
		start && instr[15:8] == `CBU_OP_NO_C |=> cond_ok == !$past(flags.carry))
		else $error("No-carry branch condition wrong");

	nonneg_cond_a : assert property (@(posedge clk) disable iff (!nrst)
		start && instr[15:8] == `CBU_OP_NON_NEG |=> cond_ok == !$past(flags.neg))
		else $error("Non-negative branch condition wrong");

	noov_cond_a : assert property (@(posedge clk) disable iff (!nrst)
		start && instr[15:8] == `CBU_OP_NO_OV |=> cond_ok == !$past(flags.ovf))
		else $error("No-overflow branch condition wrong");

	// Phase sequencer
	phase_q1_a : assert property (@(posedge clk) disable iff (!nrst)
		q_tick && q == cbu_q1 |=> q == cbu_q2)
		else $error("Phase did not leave Q1");

	phase_q2_a : assert property (@(posedge clk) disable iff (!nrst)
		q_tick && q == cbu_q2 |=> q == cbu_q3)
		else $error("Phase did not leave Q2");

	phase_q3_a : assert property (@(posedge clk) disable iff (!nrst)
		q_tick && q == cbu_q3 |=> q == cbu_q4)
		else $error("Phase did not leave Q3");

	phase_q4_a : assert property (@(posedge clk) disable iff (!nrst)
		q_tick && q == cbu_q4 |=> q == cbu_q1)
		else $error("Phase did not leave Q4");

	// Second cycle and refusal
	flush_follows_a : assert property (@(posedge clk) disable iff (!nrst)
		pc_load.load |-> flush_cyc)
		else $error("Taken branch missing second cycle");

	flush_holds_a : assert property (@(posedge clk) disable iff (!nrst)
		flush_cyc && !end_tick |=> flush_cyc)
		else $error("Second cycle cut short");

	flush_ends_a : assert property (@(posedge clk) disable iff (!nrst)
		flush_cyc && end_tick |=> !flush_cyc)
		else $error("Second cycle overran");

	flush_refuse_a : assert property (@(posedge clk) disable iff (!nrst)
		flush_cyc && q_tick && q == cbu_q1 |=> !active)
		else $error("Decode accepted in no-operation cycle");

	cycle_end_a : assert property (@(posedge clk) disable iff (!nrst)
		end_tick |=> !active)
		else $error("Branch ran past Q4");

	taken_c : cover property (@(posedge clk) disable iff (!nrst) pc_load.load);

	untaken_c : cover property (@(posedge clk) disable iff (!nrst)
		q_tick && active && !cond_ok && q == cbu_q4);

	back_off_c : cover property (@(posedge clk) disable iff (!nrst)
		pc_load.load && off_lat[7]);

	// A held word must meet the refusal during the idle cycle
	refused_c : cover property (@(posedge clk) disable iff (!nrst)
		flush_cyc && q_tick && q == cbu_q1 && instr_valid && op_hit);
endmodule : cbu_branch
`default_nettype wire

// *** cbu_fetch_model.sv ***
// Fetch path model: quarter ticks and program counter
`timescale 1ns/1ns
`default_nettype none
module cbu_fetch_model
	import cbu_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire cbu_pc_load_s pc_load,
	output logic              q_tick,
	output logic [20:0]       pc_inc
);
	logic [20:0] pc;
	// Counter already advanced past the branch word
	assign pc_inc = pc + 21'h000002;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q_tick <= 1'b0;
			pc <= 21'h000100;
		end else begin
			q_tick <= !q_tick;
			if (pc_load.load)
				pc <= pc_load.target;
		end
	end
endmodule : cbu_fetch_model
`default_nettype wire

// *** cbu_branch_bench.sv ***
// Testbench for the conditional branch unit
`timescale 1ns/1ns
`default_nettype none
module cbu_branch_bench;
	import cbu_pkg::*;
	logic         clk = 1'b0;
	logic         nrst = 1'b0;
	logic         instr_valid = 1'b0;
	logic [15:0]  instr = 16'h0000;
	cbu_flags_s   flags = 3'h0;
	logic         q_tick, is_branch, taken, flush;
	logic [1:0]   phase;
	logic [20:0]  pc_inc, exp_pc, last_t;
	cbu_pc_load_s pc_load;
	int           err_count = 0, n_compared = 0, n_load = 0, n_flush = 0;
	// Opcode, offset, flags {0,neg,ovf,carry}, taken
	logic [27:0]  rows [10] = '{28'hE605401, 28'hE605300,
		28'hE380601, 28'hE37F100, 28'hE77F301, 28'hE710400,
		28'hE5FF501, 28'hE502200, 28'hE410000, 28'h2E10100};
	cbu_branch u_cbu_branch (.clk(clk), .nrst(nrst), .q_tick(q_tick),
		.instr_valid(instr_valid), .instr(instr), .pc_inc(pc_inc), .flags(flags),
		.pc_load(pc_load), .is_branch(is_branch), .taken(taken), .flush(flush), .phase(phase));
	cbu_fetch_model u_cbu_fetch_model (.clk(clk), .nrst(nrst), .pc_load(pc_load),
		.q_tick(q_tick), .pc_inc(pc_inc));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		n_flush += (flush === 1'b1);
		if (pc_load.load === 1'b1) begin
			n_load++;
			last_t = pc_load.target;
		end
	end
	task check(input string name, input logic [20:0] seen, input logic [20:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task run(input logic [27:0] r, input int hold);
		int l0, f0;
		do @(negedge clk); while (phase !== 2'h3 || flush !== 1'b0);
		@(posedge clk);
		instr <= r[27:12];
		flags <= r[10:8];
		instr_valid <= 1'b1;
		l0 = n_load;
		f0 = n_flush;
		exp_pc = pc_inc + {{12{r[19]}}, r[19:12], 1'b0};
		repeat (4) @(posedge clk);
		@(negedge clk);
		check("is_branch", 21'(is_branch), 21'(r[27:20] inside {8'hE6, 8'hE3, 8'hE7, 8'hE5}));
		check("taken", 21'(taken), 21'(r[0]));
		repeat (hold - 4) @(posedge clk);
		instr_valid <= 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		check("loads", 21'(n_load - l0), 21'(r[0]));
		check("flush", 21'(n_flush - f0), r[0] ? 21'h000008 : 21'h000000);
		if (r[0])
			check("target", last_t, exp_pc);
		$display("test %h done", r[27:12]);
	endtask : run
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	initial begin
		#200000;
		err_count++;
		wrap_up;
	end
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk);
		check("reset outputs", 21'({pc_load.load, flush, is_branch, taken, phase}), 21'h000000);
		check("reset target", pc_load.target, 21'h000000);
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		foreach (rows[i])
			run(rows[i], 8);
		// Word held into the idle cycle must not branch twice
		run(28'hE605401, 16);
		// Reset in mid-branch drops every output at once
		@(posedge clk);
		instr_valid <= 1'b1;
		do @(negedge clk); while (is_branch !== 1'b1);
		@(posedge clk);
		nrst <= 1'b0;
		@(negedge clk);
		check("mid reset", 21'({pc_load.load, flush, is_branch, taken, phase}), 21'h000000);
		@(posedge clk);
		instr_valid <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		run(rows[0], 8);
		wrap_up;
	end
endmodule : cbu_branch_bench
`default_nettype wire
